//--- verilog/pg_mask_pkg.sv
package pg_mask_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [7:0] B_RAIL_MASK_IDX = 8'hA8;
  localparam logic [7:0] B_AUX_MASK_IDX = 8'hA9;
  localparam logic [7:0] C_RAIL_MASK_IDX = 8'hAA;
  localparam logic [7:0] C_AUX_MASK_IDX = 8'hAB;
  localparam int ADDR_W = 12;
  localparam int NUM_MASK_REGS = 4;
  localparam int MASK_W = 8;

  // Slot numbers inside the mask array.
  localparam logic [1:0] SLOT_B_RAIL = 2'h0;
  localparam logic [1:0] SLOT_B_AUX = 2'h1;
  localparam logic [1:0] SLOT_C_RAIL = 2'h2;
  localparam logic [1:0] SLOT_C_AUX = 2'h3;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int AUX_LDO_TWO_MASK_BIT = 7;
  localparam int LOAD_SWITCH_A_MASK_BIT = 6;
  localparam int STEP_DOWN_SIX_MASK_BIT = 5;
  localparam int STEP_DOWN_ONE_MASK_BIT = 0;
  localparam int CONTROL_INPUT_FIVE_MASK_BIT = 7;
  localparam int CONTROL_INPUT_FOUR_MASK_BIT = 6;
  localparam int CONTROL_INPUT_TWO_MASK_BIT = 5;
  localparam int CONTROL_INPUT_ONE_MASK_BIT = 4;
  localparam int TERMINATION_LDO_MASK_BIT = 3;
  localparam int SHARED_SWITCH_LDO_MASK_BIT = 2;
  localparam int LOAD_SWITCH_B1_MASK_BIT = 1;
  localparam int AUX_LDO_THREE_MASK_BIT = 0;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  // Held only until the one-time-programmed values are loaded.
  localparam logic [7:0] MASK_ASYNC_RESET_VAL = 8'h00;
  localparam logic [31:0] RDATA_RESET_VAL = 32'h0000_0000;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  // Same bit order as the rail mask registers.
  typedef struct packed {
    logic aux_ldo_two;
    logic load_switch_a;
    logic [5:0] step_down;
  } rail_group_t;

  // Raw power-good and pin levels of the auxiliary group.
  typedef struct packed {
    logic control_input_five;
    logic control_input_four;
    logic control_input_two;
    logic control_input_one;
    logic termination_ldo;
    logic load_switch_b2;
    logic aux_ldo_one;
    logic load_switch_b1;
    logic aux_ldo_three;
  } aux_sources_t;

  typedef struct packed {
    logic [7:0] b_rail;
    logic [7:0] b_aux;
    logic [7:0] c_rail;
    logic [7:0] c_aux;
  } mask_set_t;

endpackage

//--- verilog/power_good_mask_tree.sv
// The APB register port was decided locally.
`timescale 1ns/1ps
// What this block does
// R1: Output B has an eight-bit rail mask register at A8h: bit 7 aux LDO two, bit 6 load switch A, bits 5..0 step-down six..one.
// R2: A clear aux LDO two mask bit lets that rail's power-good into the tree and a set bit ignores it.
// R3: A clear load switch A mask bit includes its power-good and a set bit drops it.
// R4: Each step-down mask bit, bit 0 for rail one up to bit 5 for rail six, includes when clear and excludes when set.
// R5: Output B has a second mask register at A9h: bits 7..4 control inputs five, four, two, one; bits 3..0 termination LDO, shared source, switch B1, aux LDO three.
// R6: A clear control-input mask bit lets that pin's sampled state into the tree and a set bit ignores it.
// R7: The termination LDO mask bit 3 includes its power-good when clear and excludes it when set.
// R8: Mask bit 2 gates a shared source, switch B2 or aux LDO one, chosen by one-time-programmed configuration.
// R9: Mask bit 1 of the second register includes switch B1's power-good when clear and excludes it when set.
// R10: Mask bit 0 of the second register includes aux LDO three's power-good when clear and excludes it when set.
// R11: Output C has a rail mask register at AAh with the same layout and meaning as output B's first register.
// R12: Every mask field resets to a one-time-programmed value and is readable and writable.
// R13: A power-good output asserts only when every unmasked source is good; masked sources have no effect.
// R14: A mask write changes the combination feeding its output from the next clock cycle on.
// R15: Output C has a second mask register at ABh with the layout of output B's second register.
module power_good_mask_tree (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pg_mask_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire pg_mask_pkg::mask_set_t otp_mask_i,
  input wire logic otp_shared_is_ldo_i,
  input wire pg_mask_pkg::rail_group_t rail_pg_i,
  input wire pg_mask_pkg::aux_sources_t aux_pg_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic pg_output_b_o,
  output logic pg_output_c_o
);
  import pg_mask_pkg::*;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  function automatic logic [2:0] decode_slot(input logic [ADDR_W-1:0] addr);
    logic [2:0] res;
    res = 3'h4;
    if (addr == ADDR_W'({B_RAIL_MASK_IDX, 2'b00})) begin
      res = {1'b0, SLOT_B_RAIL};
    end else if (addr == ADDR_W'({B_AUX_MASK_IDX, 2'b00})) begin
      res = {1'b0, SLOT_B_AUX};
    end else if (addr == ADDR_W'({C_RAIL_MASK_IDX, 2'b00})) begin
      res = {1'b0, SLOT_C_RAIL};
    end else if (addr == ADDR_W'({C_AUX_MASK_IDX, 2'b00})) begin
      res = {1'b0, SLOT_C_AUX};
    end
    return res;
  endfunction

  // A source counts when it is good or its mask bit is set.
  function automatic logic tree_good(input logic [7:0] pg, input logic [7:0] mask);
    return &(pg | mask);
  endfunction

  logic [7:0] mask_reg [NUM_MASK_REGS];
  logic loaded_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic pg_b_reg;
  logic pg_c_reg;
  logic [2:0] slot;
  logic access_done;
  logic [7:0] aux_pg;

  assign slot = decode_slot(paddr_i);
  assign access_done = psel_i & penable_i & pready_reg;

  // ------------------------------------------------------------
  // One-time-programmed load
  // ------------------------------------------------------------
  // The reset only clears; the programmed values arrive on the first edge after release. [R12]
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Mask registers
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MASK_REGS; gi++) begin : g_mask
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          mask_reg[gi] <= MASK_ASYNC_RESET_VAL;
        end else if (!loaded_reg) begin
          mask_reg[gi] <= otp_mask_i[(NUM_MASK_REGS-1-gi)*MASK_W +: MASK_W]; // [R12]
        end else if (access_done && pwrite_i && pstrb_i[0] && slot == {1'b0, 2'(gi)}) begin
          mask_reg[gi] <= pwdata_i[7:0]; // [R1] [R5] [R11] [R15] [R12]
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // One wait-free access phase; held off until the programmed load is done so software never races it.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel_i & ~pready_reg & loaded_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= psel_i & ~pready_reg & loaded_reg & slot[2];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_reg <= RDATA_RESET_VAL;
    end else if (psel_i && !pready_reg && !pwrite_i && !slot[2]) begin
      prdata_reg <= {24'h000000, mask_reg[slot[1:0]]}; // [R12]
    end else begin
      prdata_reg <= RDATA_RESET_VAL;
    end
  end

  // ------------------------------------------------------------
  // Power-good trees
  // ------------------------------------------------------------
  // Bit 2 follows one source only, picked by the programmed option. [R8]
  assign aux_pg = {aux_pg_i.control_input_five, aux_pg_i.control_input_four,
                   aux_pg_i.control_input_two, aux_pg_i.control_input_one,
                   aux_pg_i.termination_ldo,
                   otp_shared_is_ldo_i ? aux_pg_i.aux_ldo_one : aux_pg_i.load_switch_b2,
                   aux_pg_i.load_switch_b1, aux_pg_i.aux_ldo_three};

  // Outputs are registered, so a mask written at one edge shows on the pins one edge later. [R14]
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pg_b_reg <= 1'b0;
    end else begin
      pg_b_reg <= loaded_reg & tree_good(rail_pg_i, mask_reg[SLOT_B_RAIL])
                  & tree_good(aux_pg, mask_reg[SLOT_B_AUX]); // [R2] [R3] [R4] [R6] [R7] [R9] [R10] [R13]
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pg_c_reg <= 1'b0;
    end else begin
      pg_c_reg <= loaded_reg & tree_good(rail_pg_i, mask_reg[SLOT_C_RAIL])
                  & tree_good(aux_pg, mask_reg[SLOT_C_AUX]); // [R11] [R15] [R13]
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign pg_output_b_o = pg_b_reg;
  assign pg_output_c_o = pg_c_reg;

endmodule

//--- verif/power_good_mask_tree_chk.sv
`timescale 1ns/1ps
module pg_mask_chk (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pg_mask_pkg::ADDR_W-1:0] paddr_i,
  input wire pg_mask_pkg::rail_group_t rail_pg_i,
  input wire pg_mask_pkg::aux_sources_t aux_pg_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic pg_output_b_o,
  input wire logic pg_output_c_o
);
  import pg_mask_pkg::*;
  logic mapped;
  logic good;
  assign mapped = paddr_i inside {12'h2A0, 12'h2A4, 12'h2A8, 12'h2AC};
  // All sources good means every mask setting must give a high output.
  assign good = &{rail_pg_i, aux_pg_i};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  a_ready_after_setup: assert property (psel_i && !penable_i |=> ##[0:1] pready_o)
    else $error("setup not answered");
  a_ready_one_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  a_err_unmapped: assert property (pready_o && !mapped |-> pslverr_o)
    else $error("unmapped access accepted");
  a_err_mapped: assert property (pready_o && mapped |-> !pslverr_o)
    else $error("mapped access refused");
  a_rdata_width: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_all_good_b: assert property (good [*2] |=> pg_output_b_o)
    else $error("output b low with all good");
  a_all_good_c: assert property (good [*2] |=> pg_output_c_o)
    else $error("output c low with all good");
  c_write: cover property (pready_o && pwrite_i && !pslverr_o);
  c_error: cover property (pready_o && pslverr_o);
  c_pg_rise: cover property ($rose(pg_output_b_o) ##[0:8] $rose(pg_output_c_o));
endmodule
bind power_good_mask_tree pg_mask_chk u_chk (.*);

//--- verif/tb_power_good_mask_tree.sv
`timescale 1ns/1ps
module tb_power_good_mask_tree;
  import pg_mask_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and reference model
  // ------------------------------------------------------------
  localparam logic [11:0] BASE = {2'h0, B_RAIL_MASK_IDX, 2'h0};
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, otp_shared_is_ldo_i = 1'b0, pready_o, pslverr_o;
  logic pg_output_b_o, pg_output_c_o, er;
  logic [ADDR_W-1:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] pstrb_i = 4'hF;
  mask_set_t otp_mask_i = 32'h0;
  rail_group_t rail_pg_i = 8'h0;
  aux_sources_t aux_pg_i = 9'h0;
  int failures = 0, cmp_count = 0, cyc = 0, j = 0, seed = 32'h751bcfb3;
  logic [7:0] m [4];
  logic [7:0] v;
  power_good_mask_tree dut (.*);
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // The shared source is picked by the select input, as the device does.
  function automatic logic pgm(input logic [7:0] rm, input logic [7:0] am);
    logic [7:0] ax;
    ax = {aux_pg_i[8:4], otp_shared_is_ldo_i ? aux_pg_i.aux_ldo_one : aux_pg_i.load_switch_b2, aux_pg_i[1:0]};
    return &(rail_pg_i | rm) & &(ax | am);
  endfunction
  task automatic rdall;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, BASE + 12'(4 * i), 32'h0, 4'hF);
      chk({er, rd}, {9'h0, 16'h0, m[i]});
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    otp_mask_i = $random(seed);
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    for (int i = 0; i < 4; i++) m[i] = otp_mask_i[31 - 8 * i -: 8];
    rdall();
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      apb(1'b1, BASE + 12'(4 * i), {24'h0, v}, 4'hF);
      apb(1'b1, BASE + 12'(4 * i), {24'h0, ~v}, 4'hE);
      m[i] = v;
    end
    rdall();
    // Just outside the map on both sides; nothing may be stored.
    for (int i = 0; i < 4; i++) begin
      apb(i[0], i[1] ? 12'h2B0 : 12'h29C, 32'hFF, 4'hF);
      chk({er, i[0] ? 32'h0 : rd}, {1'b1, 32'h0});
    end
    $display("test register access done");
    for (int k = 0; k < 300; k++) begin
      @(posedge sys_clk_i);
      if (k % 6 == 0) begin
        j = $random(seed) & 3;
        v = 8'($random(seed) & $random(seed));
        apb(1'b1, BASE + 12'(4 * j), {24'h0, v}, 4'hF);
        m[j] = v;
        @(negedge sys_clk_i);
        chk({31'h0, pg_output_b_o, pg_output_c_o}, {31'h0, pgm(m[0], m[1]), pgm(m[2], m[3])});
        @(posedge sys_clk_i);
      end
      rail_pg_i <= 8'($random(seed) | $random(seed) | $random(seed));
      aux_pg_i <= 9'($random(seed) | $random(seed) | $random(seed));
      otp_shared_is_ldo_i <= 1'($random(seed));
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk({31'h0, pg_output_b_o, pg_output_c_o}, {31'h0, pgm(m[0], m[1]), pgm(m[2], m[3])});
    end
    @(posedge sys_clk_i);
    rdall();
    $display("test power good trees done");
    finish_test();
  end
endmodule
